/* File: rtl/acr_cfg.svh */
// constants of the converter control register bank
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// ---------------------------------------------------------------
// register addresses and reset values
// ---------------------------------------------------------------
`define ACR_ADDR_CTRL    16'h0001
`define ACR_ADDR_GAIN    16'h0004
`define ACR_ADDR_THR     16'h0005
`define ACR_CTRL_RST     16'h0000
`define ACR_GAIN_RST     16'hA000
`define ACR_THR_RST      16'hCCCC
`define ACR_CTRL_MASK    16'h6A8F
`define ACR_SEL_CLR_MASK 16'h8700
// ---------------------------------------------------------------
// control bit positions
// ---------------------------------------------------------------
`define ACR_B_RD_THR     14
`define ACR_B_RD_GAIN    13
`define ACR_B_RD_STAT    11
`define ACR_B_SYNC       9
`define ACR_B_BYPASS     7
`define ACR_B_SLEEP      3
`define ACR_B_ECO        2
`define ACR_B_REFOFF     1
`define ACR_B_INSTAGE    0
// ---------------------------------------------------------------
// status word layout
// ---------------------------------------------------------------
`define ACR_STAT_FIXED   16'h4840
`define ACR_S_PART       15
`define ACR_S_VALID      10
`define ACR_S_ECO        9
`define ACR_S_OVR        8
`define ACR_S_REFOFF     4
`define ACR_S_INSTAGE    3
`define ACR_S_DEC        0
// ---------------------------------------------------------------
// frame and timing counts
// ---------------------------------------------------------------
`define ACR_FRAME_LAST   6'd31
`define ACR_FRAME_BITS   6'd32
`define ACR_SETTLE_DEF   8192
`define ACR_CONV_BITS    24
`endif

/* File: rtl/acr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acr_pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= RST_VAL;
        end else if (s2_reg == s3_reg) begin
            level <= s3_reg;
        end
    end
endmodule

/* File: rtl/acr_pkg.sv */
// types of the converter control register bank
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_SRC_CONV,
        ACR_SRC_THR,
        ACR_SRC_GAIN,
        ACR_SRC_STAT
    } acr_src_type;
endpackage

/* File: rtl/acr_top.sv */
// converter control register bank with serial write and read frames
// Functional notes
// - after start-up output is readable with default gain and threshold
// - data invalid until settling elapses, then data-valid flag sets
// - gain and threshold registers writable and readable after start-up
// - write is address word then 16-bit data stored at that address
// - control register at address 0x0001, reset value 0x0000
// - control bits: selects 14,13,11, sync 9, bypass 7, sleep/eco/ref/amp 3..0
// - control writes steer reference buffer, amplifier and power-down
// - readback selects and sync bit clear themselves after taking effect
// - readback select substitutes the chosen register in the next read frame
// - sleep bit powers down without reset; writing zero wakes the converter
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_top #(
    parameter int             SETTLE_CYCLES = `ACR_SETTLE_DEF,
    parameter logic           PART_BIT      = 1'b0
) (
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         RESET_N,
    input  wire logic         SYNC_N,
    input  wire logic         FSI_N,
    input  wire logic         SDI,
    input  wire logic [23:0]  CONV_RESULT,
    input  wire logic         CONV_STROBE,
    input  wire logic         OVR_IN,
    input  wire logic         DEC_SEL,
    output logic              SCO,
    output logic              SDO,
    output logic              FSO_N,
    output logic [15:0]       GAIN_VALUE,
    output logic [15:0]       THRESHOLD_VALUE,
    output logic              SLEEP_REQUEST,
    output logic              ECONOMY_OPERATION,
    output logic              REF_BUF_DISABLE,
    output logic              REF_BYPASS,
    output logic              INPUT_STAGE_DISABLE,
    output logic              FILTER_SYNC,
    output logic              DATA_VALID_FLAG
);
    // ---------------------------------------------------------------
    // pin synchronisers and internal reset
    // ---------------------------------------------------------------
    logic        reset_n_s;
    logic        sync_n_s;
    logic        fsi_n_s;
    logic        sdi_s;
    logic        rst_int;
    logic        sync_n_prev_reg;
    logic [15:0] ctrl_reg;
    logic        sco_reg;
    logic [5:0]  rx_cnt_reg;
    logic [30:0] rx_sh_reg;
    logic        wr_strobe;
    logic [31:0] wr_word;
    logic        wr_ctrl;
    logic        sync_evt;
    logic [31:0] settle_cnt_reg;
    logic        tx_busy_reg;
    logic [5:0]  tx_cnt_reg;
    logic [31:0] tx_sh_reg;
    logic        frame_load;
    logic [15:0] stat_word;
    logic [31:0] frame_word;
    acr_pkg::acr_src_type src;

    acr_pin_sync #(.RST_VAL(1'b1)) u_rst_sync  (.clk(CLK), .rst(SYS_RST), .pin(RESET_N), .level(reset_n_s));
    acr_pin_sync #(.RST_VAL(1'b1)) u_sync_sync (.clk(CLK), .rst(SYS_RST), .pin(SYNC_N),  .level(sync_n_s));
    acr_pin_sync #(.RST_VAL(1'b1)) u_fsi_sync  (.clk(CLK), .rst(SYS_RST), .pin(FSI_N),   .level(fsi_n_s));
    acr_pin_sync #(.RST_VAL(1'b0)) u_sdi_sync  (.clk(CLK), .rst(SYS_RST), .pin(SDI),     .level(sdi_s));

    // reset pin sampled on the master clock
    assign rst_int = SYS_RST | ~reset_n_s;

    // ---------------------------------------------------------------
    // serial clock and write frame receiver
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (rst_int) begin
            sco_reg <= 1'b0;
        end else begin
            sco_reg <= ~sco_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            rx_cnt_reg <= 6'd0;
            rx_sh_reg  <= 31'd0;
        end else if (sco_reg) begin
            if (fsi_n_s) begin
                rx_cnt_reg <= 6'd0;
            end else begin
                rx_sh_reg <= {rx_sh_reg[29:0], sdi_s};
                if (rx_cnt_reg != `ACR_FRAME_BITS) begin
                    rx_cnt_reg <= rx_cnt_reg + 6'd1;
                end
            end
        end
    end

    // address word then data word
    assign wr_word   = {rx_sh_reg, sdi_s};
    assign wr_strobe = sco_reg & ~fsi_n_s & (rx_cnt_reg == `ACR_FRAME_LAST);
    assign wr_ctrl   = wr_strobe & (wr_word[31:16] == `ACR_ADDR_CTRL);

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (rst_int) begin
            ctrl_reg <= `ACR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= wr_word[15:0] & `ACR_CTRL_MASK;
        end else begin
            if (ctrl_reg[`ACR_B_SYNC]) begin
                ctrl_reg[`ACR_B_SYNC] <= 1'b0;
            end
            if (frame_load) begin
                ctrl_reg[`ACR_B_RD_THR:`ACR_B_RD_STAT] <= 4'd0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            GAIN_VALUE      <= `ACR_GAIN_RST;
            THRESHOLD_VALUE <= `ACR_THR_RST;
        end else if (wr_strobe) begin
            if (wr_word[31:16] == `ACR_ADDR_GAIN) begin
                GAIN_VALUE <= wr_word[15:0];
            end else if (wr_word[31:16] == `ACR_ADDR_THR) begin
                THRESHOLD_VALUE <= wr_word[15:0];
            end
        end
    end

    // control bits drive the analog blocks; sleep keeps all state
    assign SLEEP_REQUEST       = ctrl_reg[`ACR_B_SLEEP];
    assign ECONOMY_OPERATION   = ctrl_reg[`ACR_B_ECO];
    assign REF_BUF_DISABLE     = ctrl_reg[`ACR_B_REFOFF];
    assign REF_BYPASS          = ctrl_reg[`ACR_B_BYPASS];
    assign INPUT_STAGE_DISABLE = ctrl_reg[`ACR_B_INSTAGE];

    // ---------------------------------------------------------------
    // synchronisation and filter settling
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (rst_int) begin
            sync_n_prev_reg <= 1'b1;
            FILTER_SYNC     <= 1'b0;
        end else begin
            sync_n_prev_reg <= sync_n_s;
            FILTER_SYNC     <= sync_evt;
        end
    end

    assign sync_evt = ctrl_reg[`ACR_B_SYNC] | (sync_n_prev_reg & ~sync_n_s);

    always_ff @(posedge CLK) begin
        if (rst_int || sync_evt) begin
            settle_cnt_reg  <= 32'd0;
            DATA_VALID_FLAG <= 1'b0;
        end else if (!SLEEP_REQUEST && !DATA_VALID_FLAG) begin
            if (settle_cnt_reg == 32'(SETTLE_CYCLES - 1)) begin
                DATA_VALID_FLAG <= 1'b1;
            end else begin
                settle_cnt_reg <= settle_cnt_reg + 32'd1;
            end
        end
    end

    // ---------------------------------------------------------------
    // read frame transmitter
    // ---------------------------------------------------------------
    assign stat_word = `ACR_STAT_FIXED
                     | (16'(PART_BIT) << `ACR_S_PART)
                     | (16'(DATA_VALID_FLAG) << `ACR_S_VALID)
                     | (16'(ctrl_reg[`ACR_B_ECO]) << `ACR_S_ECO)
                     | (16'(OVR_IN) << `ACR_S_OVR)
                     | (16'(ctrl_reg[`ACR_B_REFOFF]) << `ACR_S_REFOFF)
                     | (16'(ctrl_reg[`ACR_B_INSTAGE]) << `ACR_S_INSTAGE)
                     | (16'(DEC_SEL) << `ACR_S_DEC);

    always_comb begin
        if (ctrl_reg[`ACR_B_RD_THR]) begin
            src = acr_pkg::ACR_SRC_THR;
        end else if (ctrl_reg[`ACR_B_RD_GAIN]) begin
            src = acr_pkg::ACR_SRC_GAIN;
        end else if (ctrl_reg[`ACR_B_RD_STAT]) begin
            src = acr_pkg::ACR_SRC_STAT;
        end else begin
            src = acr_pkg::ACR_SRC_CONV;
        end
    end

    always_comb begin
        case (src)
            acr_pkg::ACR_SRC_THR:  frame_word = {THRESHOLD_VALUE, 16'h0000};
            acr_pkg::ACR_SRC_GAIN: frame_word = {GAIN_VALUE, 16'h0000};
            acr_pkg::ACR_SRC_STAT: frame_word = {stat_word, 16'h0000};
            default:               frame_word = {CONV_RESULT, DATA_VALID_FLAG, OVR_IN, 6'h00};
        endcase
    end

    // a write frame overrides any read
    assign frame_load = CONV_STROBE & ~sco_reg & ~tx_busy_reg & fsi_n_s & ~SLEEP_REQUEST;

    always_ff @(posedge CLK) begin
        if (rst_int || !fsi_n_s) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg  <= 6'd0;
            tx_sh_reg   <= 32'd0;
            SDO         <= 1'b0;
            FSO_N       <= 1'b1;
        end else if (frame_load) begin
            tx_busy_reg <= 1'b1;
            tx_cnt_reg  <= `ACR_FRAME_LAST;
            tx_sh_reg   <= {frame_word[30:0], 1'b0};
            SDO         <= frame_word[31];
            FSO_N       <= 1'b0;
        end else if (tx_busy_reg && !sco_reg) begin
            if (tx_cnt_reg == 6'd0) begin
                tx_busy_reg <= 1'b0;
                FSO_N       <= 1'b1;
                SDO         <= 1'b0;
            end else begin
                tx_cnt_reg <= tx_cnt_reg - 6'd1;
                SDO        <= tx_sh_reg[31];
                tx_sh_reg  <= {tx_sh_reg[30:0], 1'b0};
            end
        end
    end

    assign SCO = sco_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_thr_select;
        frame_load && ctrl_reg[`ACR_B_RD_THR];
    endsequence

    sequence s_sel_consumed;
        frame_load && !wr_ctrl;
    endsequence

    a_reset_defaults: assert property (@(posedge CLK)
        rst_int |=> (ctrl_reg == `ACR_CTRL_RST && GAIN_VALUE == `ACR_GAIN_RST
                     && THRESHOLD_VALUE == `ACR_THR_RST && !DATA_VALID_FLAG))
        else $error("reset did not restore defaults");

    a_ctrl_write_store: assert property (@(posedge CLK) disable iff (rst_int)
        wr_ctrl |=> ctrl_reg == ($past(wr_word[15:0]) & `ACR_CTRL_MASK))
        else $error("control write not stored");

    a_gain_write_store: assert property (@(posedge CLK) disable iff (rst_int)
        (wr_strobe && wr_word[31:16] == `ACR_ADDR_GAIN) |=> GAIN_VALUE == $past(wr_word[15:0]))
        else $error("gain write not stored");

    a_sync_self_clear: assert property (@(posedge CLK) disable iff (rst_int)
        (ctrl_reg[`ACR_B_SYNC] && !wr_ctrl) |=> (!ctrl_reg[`ACR_B_SYNC] && FILTER_SYNC))
        else $error("sync bit did not clear or pulse");

    a_select_self_clear: assert property (@(posedge CLK) disable iff (rst_int)
        s_sel_consumed |=> ctrl_reg[`ACR_B_RD_THR:`ACR_B_RD_STAT] == 4'd0)
        else $error("readback select did not clear");

    a_thr_readback: assert property (@(posedge CLK) disable iff (rst_int || !fsi_n_s)
        s_thr_select |=> (!FSO_N && SDO == $past(THRESHOLD_VALUE[15]))
                         ##2 (SDO == $past(THRESHOLD_VALUE[14], 3)))
        else $error("threshold not substituted in frame");

    a_valid_after_settle: assert property (@(posedge CLK) disable iff (rst_int)
        (sync_evt |=> !DATA_VALID_FLAG) and
        ((settle_cnt_reg == 32'(SETTLE_CYCLES - 1) && !sync_evt && !SLEEP_REQUEST) |=> DATA_VALID_FLAG))
        else $error("data-valid flag timing wrong");

    a_sleep_keeps_state: assert property (@(posedge CLK) disable iff (rst_int)
        (wr_ctrl && wr_word[`ACR_B_SLEEP]) |=> (SLEEP_REQUEST && $stable(GAIN_VALUE) && $stable(THRESHOLD_VALUE)))
        else $error("sleep lost state");

    a_default_output: assert property (@(posedge CLK)
        $fell(rst_int) |-> (GAIN_VALUE == `ACR_GAIN_RST && THRESHOLD_VALUE == `ACR_THR_RST))
        else $error("defaults missing after start-up");
endmodule

/* File: test/acr_host_model.sv */
// host controller model driving the serial write link and control pins
`timescale 1ns/1ps
module acr_host_model (
    input  wire logic clk,
    input  wire logic sco,
    output logic      reset_n,
    output logic      sync_n,
    output logic      fsi_n,
    output logic      sdi
);
    // ----------------------------------------
    // idle levels and host sequences
    // ----------------------------------------
    initial begin
        reset_n = 1'b1;
        sync_n  = 1'b1;
        fsi_n   = 1'b1;
        sdi     = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one low pulse on reset_n, changed on falling edge
    task automatic reset_pulse(input int n);
        @(negedge clk);
        reset_n = 1'b0;
        pause(n);
        reset_n = 1'b1;
        pause(8);
    endtask

    task automatic sync_pulse(input int n);
        @(negedge clk);
        sync_n = 1'b0;
        pause(n);
        sync_n = 1'b1;
        pause(8);
    endtask

    // address word then data word, msb first, one bit per serial period
    task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
        logic [31:0] w;
        w = {addr, data};
        for (int i = 31; i >= 0; i--) begin
            do @(negedge clk); while (sco !== 1'b1);
            fsi_n = 1'b0;
            sdi   = w[i];
        end
        do @(negedge clk); while (sco !== 1'b1);
        fsi_n = 1'b1;
        sdi   = ~sdi;
        pause(8);
    endtask
endmodule

/* File: test/acr_top_tb.sv */
// self-checking bench of the converter control register bank
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_top_tb;
    localparam logic [31:0] conv_word = 32'hA5C33CC0;
    localparam logic [15:0] stat_base = `ACR_STAT_FIXED | 16'h0501;
    logic        clk;
    logic        sys_rst;
    logic [23:0] conv_result;
    logic        conv_strobe;
    logic        ovr_in;
    logic        dec_sel;
    wire         reset_n;
    wire         sync_n;
    wire         fsi_n;
    wire         sdi;
    logic        sco;
    logic        sdo;
    logic        fso_n;
    logic [15:0] gain_value;
    logic [15:0] threshold_value;
    logic [4:0]  ctrl_bits;
    logic        filter_sync;
    logic        data_valid_flag;
    logic [31:0] word;
    logic        seen;
    int          err_total;
    int          cmp_count;
    int          cycles;
    int          sync_seen;

    acr_top #(.SETTLE_CYCLES(16), .PART_BIT(1'b0)) uut (
        .CLK(clk), .SYS_RST(sys_rst), .RESET_N(reset_n), .SYNC_N(sync_n), .FSI_N(fsi_n), .SDI(sdi),
        .CONV_RESULT(conv_result), .CONV_STROBE(conv_strobe), .OVR_IN(ovr_in), .DEC_SEL(dec_sel),
        .SCO(sco), .SDO(sdo), .FSO_N(fso_n), .GAIN_VALUE(gain_value), .THRESHOLD_VALUE(threshold_value),
        .SLEEP_REQUEST(ctrl_bits[4]), .ECONOMY_OPERATION(ctrl_bits[3]), .REF_BUF_DISABLE(ctrl_bits[2]),
        .REF_BYPASS(ctrl_bits[1]), .INPUT_STAGE_DISABLE(ctrl_bits[0]), .FILTER_SYNC(filter_sync),
        .DATA_VALID_FLAG(data_valid_flag)
    );

    acr_host_model host (
        .clk(clk), .sco(sco), .reset_n(reset_n), .sync_n(sync_n), .fsi_n(fsi_n), .sdi(sdi)
    );

    // ----------------------------------------
    // clock, timeout and pulse counter
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    always @(negedge clk) begin
        if (filter_sync === 1'b1) sync_seen = sync_seen + 1;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic read_frame(output logic [31:0] w, output logic s);
        int n;
        w = 32'h0;
        do @(negedge clk); while (sco !== 1'b0);
        conv_strobe = 1'b1;
        @(negedge clk);
        conv_strobe = 1'b0;
        for (n = 0; n < 4 && fso_n !== 1'b0; n++) @(negedge clk);
        s = (fso_n === 1'b0);
        if (s) begin
            for (int i = 31; i >= 0; i--) begin
                w[i] = sdo;
                repeat (2) @(negedge clk);
            end
            check({31'h0, fso_n}, 32'h1);
        end
    endtask

    // select one source, read it, then expect a conversion frame again
    task automatic readback(input logic [15:0] ctrl, input logic [15:0] exp);
        host.write_reg(`ACR_ADDR_CTRL, ctrl);
        read_frame(word, seen);
        check(word, {exp, 16'h0000});
        read_frame(word, seen);
        check(word, conv_word);
    endtask

    task automatic wait_valid();
        int n;
        for (n = 0; n < 64 && data_valid_flag !== 1'b1; n++) @(negedge clk);
        check({31'h0, data_valid_flag}, 32'h1);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        sync_seen = 0;
        sys_rst = 1'b1;
        conv_result = 24'hA5C33C;
        conv_strobe = 1'b0;
        ovr_in = 1'b1;
        dec_sel = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
        check({gain_value, threshold_value}, {`ACR_GAIN_RST, `ACR_THR_RST});
        check({27'h0, ctrl_bits}, 32'h0);
        check({31'h0, data_valid_flag}, 32'h0);
        wait_valid();
        read_frame(word, seen);
        check(word, conv_word);
        readback(16'h4000, `ACR_THR_RST);
        readback(16'h2000, `ACR_GAIN_RST);
        readback(16'h0800, stat_base);
        host.write_reg(`ACR_ADDR_GAIN, 16'h1234);
        host.write_reg(`ACR_ADDR_THR, 16'h5678);
        host.write_reg(16'h0007, 16'hFFFF);
        check({gain_value, threshold_value}, 32'h12345678);
        readback(16'h2000, 16'h1234);
        readback(16'h4000, 16'h5678);
        host.write_reg(`ACR_ADDR_CTRL, 16'h0087);
        check({27'h0, ctrl_bits}, 32'h0F);
        readback(16'h0887, stat_base | 16'h0218);
        check({27'h0, ctrl_bits}, 32'h0F);
        host.write_reg(`ACR_ADDR_CTRL, 16'h0008);
        check({27'h0, ctrl_bits}, 32'h10);
        read_frame(word, seen);
        check({31'h0, seen}, 32'h0);
        check({16'h0, gain_value}, 32'h1234);
        host.write_reg(`ACR_ADDR_CTRL, 16'h9570);
        check({27'h0, ctrl_bits}, 32'h0);
        read_frame(word, seen);
        check(word, conv_word);
        // overrange low reaches both frame kinds, slow decimation only the status frame
        ovr_in = 1'b0;
        dec_sel = 1'b0;
        read_frame(word, seen);
        check(word, {conv_result, 8'h80});
        host.write_reg(`ACR_ADDR_CTRL, 16'h0800);
        read_frame(word, seen);
        check(word, {`ACR_STAT_FIXED | 16'h0400, 16'h0000});
        ovr_in = 1'b1;
        dec_sel = 1'b1;
        host.write_reg(`ACR_ADDR_CTRL, 16'h0200);
        check(sync_seen, 1);
        check({31'h0, data_valid_flag}, 32'h0);
        wait_valid();
        host.sync_pulse(4);
        check(sync_seen, 2);
        host.reset_pulse(6);
        check({gain_value, threshold_value}, {`ACR_GAIN_RST, `ACR_THR_RST});
        check({31'h0, data_valid_flag}, 32'h0);
        wait_valid();
        report_and_stop();
    end
endmodule
